// [logic/tse_pkg.sv]
// constants and types for the trimming sequence editor
// Overview of operation
// [RULE_01] store key plus A enters parameter change
// [RULE_02] key B enters group B item one
// [RULE_03] A and B step item number
// [RULE_04] C at item 55 blinks sequence indicator
// [RULE_05] second C shows start value 80
// [RULE_06] A and B change current byte
// [RULE_07] C and D move location, show byte
// [RULE_08] store key writes edited sequence
// [RULE_09] location index is never displayed
// [RULE_10] key E leaves edit, saves all
// [RULE_11] entry is command byte plus data
// [RULE_12] program holds at most 64 bytes
// [RULE_13] count stitch command carries speed, count
// [RULE_14] data field holds zero to three bytes
// [RULE_15] sequences open with 08, close 00
// [RULE_16] selection setting picks sequence, default 0
// [RULE_17] interpreter runs commands until end code
// [RULE_18] location index stops at area end
package tse_pkg;
  localparam int PROG_BYTES = 64;
  localparam int IDX_W = 6;
  localparam int ITEM_W = 7;
  localparam logic [ITEM_W-1:0] ITEM_FIRST = 7'h01;
  localparam logic [ITEM_W-1:0] ITEM_MAX = 7'h63;
  localparam logic [ITEM_W-1:0] ITEM_SEQ = 7'h37;
  localparam logic [7:0] CODE_SEQ_START = 8'h08;
  localparam logic [7:0] CODE_SEQ_END = 8'h00;
  localparam logic [7:0] CODE_FIRST_SHOWN = 8'h80;
  localparam logic [7:0] CODE_POS_STOP = 8'hCE;
  localparam logic [7:0] CODE_OUT_LO = 8'h81;
  localparam logic [7:0] CODE_OUT_HI = 8'hAB;
  localparam logic [7:0] CODE_DLY_LO = 8'hB0;
  localparam logic [7:0] CODE_DLY_HI = 8'hB3;
  localparam logic [7:0] CODE_GENERAL = 8'hF3;
  // display modes
  typedef enum logic [2:0] {
    DISP_IDLE, DISP_EDIT_ENABLE, DISP_ITEM, DISP_SEQ_BLINK, DISP_VALUE
  } tse_disp_t;
  // data bytes per command
  function automatic logic [1:0] data_count(input logic [7:0] c);
    if (c == CODE_POS_STOP) return 2'd2;
    if (c >= CODE_DLY_LO && c <= CODE_DLY_HI) return 2'd1;
    return 2'd0;
  endfunction
endpackage

// [logic/tse_editor.sv]
// trimming sequence editor and interpreter
`timescale 1ns/1ps
module tse_editor #(
  parameter int DEPTH = tse_pkg::PROG_BYTES
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic KEY_A_IN,
  input wire logic KEY_B_IN,
  input wire logic KEY_C_IN,
  input wire logic KEY_D_IN,
  input wire logic KEY_E_IN,
  input wire logic KEY_STORE_IN,
  input wire logic [3:0] SEQ_SELECT_IN,
  input wire logic RUN_IN,
  output logic [2:0] DISP_MODE_OUT,
  output logic [7:0] DISP_VALUE_OUT,
  output logic [6:0] DISP_ITEM_OUT,
  output logic SAVE_OUT,
  output logic CMD_VALID_OUT,
  output logic [7:0] CMD_CODE_OUT,
  output logic [7:0] CMD_DATA1_OUT,
  output logic [7:0] CMD_DATA2_OUT,
  output logic [7:0] CMD_DATA3_OUT,
  output logic RUN_DONE_OUT
);
  import tse_pkg::*;

  // elaboration checks: the index and program widths are fixed
  if (DEPTH != PROG_BYTES) begin : g_bad_depth
    $error("DEPTH must equal PROG_BYTES");
  end
  if ((1 << IDX_W) < DEPTH) begin : g_bad_index
    $error("IDX_W too narrow for DEPTH");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ENABLE, ST_ITEM, ST_SEQ, ST_EDIT
  } tse_state_t;
  typedef enum logic [1:0] {RN_IDLE, RN_SEEK, RN_CMD, RN_DATA} tse_run_t;

  // step a location or program counter by one
  function automatic logic [IDX_W-1:0] step_loc(input logic [IDX_W-1:0] v);
    return v + IDX_W'(1);
  endfunction

  // default program: shown start value, one sequence, then end codes
  function automatic logic [7:0] default_byte(input int idx);
    unique case (idx)
      0: return CODE_FIRST_SHOWN; // [RULE_05]
      1: return CODE_SEQ_START; // [RULE_15]
      2: return CODE_GENERAL;
      default: return CODE_SEQ_END;
    endcase
  endfunction

  // two-stage key synchronisers with a third stage for edge detection
  logic [5:0] k_s1_q;
  logic [5:0] k_s2_q;
  logic [5:0] k_prev_q;
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      k_s1_q <= '0;
      k_s2_q <= '0;
      k_prev_q <= '0;
    end else begin
      k_s1_q <= {KEY_STORE_IN, KEY_E_IN, KEY_D_IN, KEY_C_IN, KEY_B_IN,
                 KEY_A_IN};
      k_s2_q <= k_s1_q;
      k_prev_q <= k_s2_q;
    end
  end

  // selection synchroniser; the level must be steady before a run starts
  logic [3:0] sel_s1_q;
  logic [3:0] sel_s2_q;
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sel_s1_q <= '0;
      sel_s2_q <= '0;
    end else begin
      sel_s1_q <= SEQ_SELECT_IN;
      sel_s2_q <= sel_s1_q;
    end
  end

  // run request synchroniser; low reset value matches the idle pin
  logic run_s1_q;
  logic run_s2_q;
  logic run_prev_q;
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_s1_q <= RUN_IN;
      run_s2_q <= run_s1_q;
      run_prev_q <= run_s2_q;
    end
  end

  logic [5:0] press;
  assign press = k_s2_q & ~k_prev_q;
  logic combo;
  assign combo = k_s2_q[5] & k_s2_q[0] & (press[5] | press[0]);
  logic run_go;
  assign run_go = run_s2_q & ~run_prev_q;

  // working copy and stored program
  logic [7:0] work_mem [DEPTH];
  logic [7:0] store_mem [DEPTH];
  tse_state_t st_q;
  logic [ITEM_W-1:0] item_q;
  logic [IDX_W-1:0] loc_q;
  logic save_q;

  // menu state machine
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_q <= ST_IDLE;
      item_q <= ITEM_FIRST;
      loc_q <= '0;
      save_q <= 1'b0;
    end else begin
      save_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (combo) st_q <= ST_ENABLE; // [RULE_01]
        end
        ST_ENABLE: begin
          if (press[1]) begin
            st_q <= ST_ITEM; // [RULE_02]
            item_q <= ITEM_FIRST;
          end
        end
        ST_ITEM: begin
          if (press[0] && item_q != ITEM_MAX)
            item_q <= item_q + 7'h01; // [RULE_03]
          else if (press[1] && item_q != ITEM_FIRST)
            item_q <= item_q - 7'h01; // [RULE_03]
          else if (press[2] && item_q == ITEM_SEQ)
            st_q <= ST_SEQ; // [RULE_04]
        end
        ST_SEQ: begin
          if (press[2]) begin
            st_q <= ST_EDIT; // [RULE_05]
            loc_q <= '0;
          end
        end
        ST_EDIT: begin
          if (press[2] && loc_q != IDX_W'(DEPTH - 1))
            loc_q <= step_loc(loc_q); // [RULE_07] [RULE_18]
          else if (press[3] && loc_q != '0)
            loc_q <= loc_q - 6'h01; // [RULE_07]
          else if (press[5]) begin
            save_q <= 1'b1; // [RULE_08]
          end else if (press[4]) begin
            save_q <= 1'b1; // [RULE_10]
            st_q <= ST_ENABLE;
          end
        end
      endcase
    end
  end

  // loaded flag: low after reset, so the default program is written
  // into both copies; a reset therefore also drops any stored edits
  logic loaded_q;
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) loaded_q <= 1'b0;
    else loaded_q <= 1'b1;
  end

  // working copy edit and commit to store, one writer for each array
  always_ff @(posedge CLK_IN) begin
    if (!loaded_q) begin
      for (int i = 0; i < DEPTH; i++) begin
        work_mem[i] <= default_byte(i);
        store_mem[i] <= default_byte(i);
      end
    end else begin
      if (st_q == ST_EDIT && press[0])
        work_mem[loc_q] <= work_mem[loc_q] + 8'h01; // [RULE_06]
      else if (st_q == ST_EDIT && press[1])
        work_mem[loc_q] <= work_mem[loc_q] - 8'h01; // [RULE_06]
      if (save_q) begin
        for (int i = 0; i < DEPTH; i++) begin
          store_mem[i] <= work_mem[i]; // [RULE_10]
        end
      end
    end
  end

  // save pulse follows the menu one cycle later
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SAVE_OUT <= 1'b0;
    end else begin
      SAVE_OUT <= save_q;
    end
  end

  // group B item number as shown
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      DISP_ITEM_OUT <= 7'h00;
    end else begin
      DISP_ITEM_OUT <= item_q;
    end
  end

  // shown byte: only the value, never the location index
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      DISP_VALUE_OUT <= 8'h00;
    end else begin
      DISP_VALUE_OUT <= (st_q == ST_EDIT) ?
                        work_mem[loc_q] : 8'h00; // [RULE_09]
    end
  end

  // display mode follows the menu state one cycle later
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      DISP_MODE_OUT <= DISP_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: DISP_MODE_OUT <= DISP_IDLE;
        ST_ENABLE: DISP_MODE_OUT <= DISP_EDIT_ENABLE; // [RULE_01]
        ST_ITEM: DISP_MODE_OUT <= DISP_ITEM;
        ST_SEQ: DISP_MODE_OUT <= DISP_SEQ_BLINK; // [RULE_04]
        ST_EDIT: DISP_MODE_OUT <= DISP_VALUE;
      endcase
    end
  end

  // interpreter over stored program
  tse_run_t rn_q;
  logic [IDX_W-1:0] pc_q;
  logic [3:0] seen_q;
  logic [1:0] need_q, got_q;
  logic [7:0] byte_now;
  logic at_end;
  assign byte_now = store_mem[pc_q];
  assign at_end = (pc_q == IDX_W'(DEPTH - 1)); // [RULE_12]
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rn_q <= RN_IDLE;
      pc_q <= '0;
      seen_q <= '0;
      need_q <= '0;
      got_q <= '0;
      CMD_VALID_OUT <= 1'b0;
      CMD_CODE_OUT <= 8'h00;
      CMD_DATA1_OUT <= 8'h00;
      CMD_DATA2_OUT <= 8'h00;
      CMD_DATA3_OUT <= 8'h00;
      RUN_DONE_OUT <= 1'b0;
    end else begin
      CMD_VALID_OUT <= 1'b0;
      RUN_DONE_OUT <= 1'b0;
      unique case (rn_q)
        RN_IDLE: begin
          if (run_go) begin
            rn_q <= RN_SEEK;
            pc_q <= '0;
            seen_q <= '0;
          end
        end
        RN_SEEK: begin
          if (byte_now == CODE_SEQ_START && seen_q == sel_s2_q) begin
            rn_q <= RN_CMD; // [RULE_16]
          end else if (at_end) begin
            rn_q <= RN_IDLE;
            RUN_DONE_OUT <= 1'b1;
          end
          if (byte_now == CODE_SEQ_START) seen_q <= seen_q + 4'h1; // [RULE_15]
          if (!at_end) pc_q <= pc_q + 6'h01;
        end
        RN_CMD: begin
          if (byte_now == CODE_SEQ_END || at_end) begin
            rn_q <= RN_IDLE; // [RULE_17]
            RUN_DONE_OUT <= 1'b1;
          end else begin
            CMD_CODE_OUT <= byte_now; // [RULE_11]
            CMD_DATA1_OUT <= 8'h00;
            CMD_DATA2_OUT <= 8'h00;
            CMD_DATA3_OUT <= 8'h00;
            need_q <= data_count(byte_now); // [RULE_13] [RULE_14]
            got_q <= '0;
            pc_q <= step_loc(pc_q);
            if (data_count(byte_now) == 2'd0) CMD_VALID_OUT <= 1'b1;
            else rn_q <= RN_DATA;
          end
        end
        RN_DATA: begin
          unique case (got_q)
            2'd0: CMD_DATA1_OUT <= byte_now; // [RULE_14]
            2'd1: CMD_DATA2_OUT <= byte_now;
            default: CMD_DATA3_OUT <= byte_now;
          endcase
          got_q <= got_q + 2'd1;
          if (got_q + 2'd1 == need_q || at_end) begin
            CMD_VALID_OUT <= 1'b1; // [RULE_17]
            rn_q <= at_end ? RN_IDLE : RN_CMD;
            RUN_DONE_OUT <= at_end;
          end
          if (!at_end) pc_q <= pc_q + 6'h01;
        end
      endcase
    end
  end
endmodule

// [verification/tse_editor_checker.sv]
// port assertions for the trimming sequence editor
`timescale 1ns/1ps
module tse_editor_checker import tse_pkg::*; (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [2:0] DISP_MODE_OUT,
  input wire logic [7:0] DISP_VALUE_OUT,
  input wire logic [6:0] DISP_ITEM_OUT,
  input wire logic SAVE_OUT,
  input wire logic RUN_DONE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // display mode stepped from one value to another
  sequence mode_step(logic [2:0] a, logic [2:0] b);
    $past(DISP_MODE_OUT) == a && DISP_MODE_OUT == b;
  endsequence
  // saves happen only around the edit state
  sequence near_edit;
    DISP_MODE_OUT == 3'h4 || $past(DISP_MODE_OUT) == 3'h4 ||
      $past(DISP_MODE_OUT, 2) == 3'h4;
  endsequence
  mode_legal_a: assert property (DISP_MODE_OUT <= 3'h4)
    else $error("display mode out of range");
  value_hidden_a: assert property (DISP_MODE_OUT != 3'h4 |->
    DISP_VALUE_OUT == 8'h00) else $error("value shown outside edit");
  item_range_a: assert property (DISP_MODE_OUT == 3'h2 |->
    DISP_ITEM_OUT inside {[ITEM_FIRST:ITEM_MAX]}) else $error("item range");
  group_entry_a: assert property (mode_step(3'h1, 3'h2) |->
    DISP_ITEM_OUT == ITEM_FIRST) else $error("group not at first item");
  blink_item_a: assert property (mode_step(3'h2, 3'h3) |->
    DISP_ITEM_OUT == ITEM_SEQ) else $error("blink away from item 55");
  value_entry_a: assert property (DISP_MODE_OUT == 3'h4 &&
    $past(DISP_MODE_OUT) != 3'h4 |-> $past(DISP_MODE_OUT) == 3'h3)
    else $error("edit entered from wrong state");
  save_pulse_a: assert property (SAVE_OUT |=> !SAVE_OUT)
    else $error("save longer than one cycle");
  save_edit_a: assert property (SAVE_OUT |-> near_edit)
    else $error("save outside edit");
  done_pulse_a: assert property (RUN_DONE_OUT |=> !RUN_DONE_OUT)
    else $error("done longer than one cycle");
endmodule
bind tse_editor tse_editor_checker i_tse_editor_checker (
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .DISP_MODE_OUT(DISP_MODE_OUT),
  .DISP_VALUE_OUT(DISP_VALUE_OUT), .DISP_ITEM_OUT(DISP_ITEM_OUT),
  .SAVE_OUT(SAVE_OUT), .RUN_DONE_OUT(RUN_DONE_OUT));

// [verification/tse_panel.sv]
// panel model that presses one key at a time, or store held together with a
`timescale 1ns/1ps
module tse_panel (
  input wire logic clk_in,
  output logic [4:0] keys_out,
  output logic store_out
);
  initial begin
    keys_out = 5'h00;
    store_out = 1'b0;
  end
  // k: 0..4 keys a..e, 5 store held then a, 6 store alone
  task automatic press(input logic [2:0] k);
    @(posedge clk_in);
    store_out <= (k >= 3'h5);
    repeat (2) @(posedge clk_in);
    keys_out <= (k == 3'h6) ? 5'h00 : (k == 3'h5) ? 5'h01 : 5'h01 << k;
    repeat (4) @(posedge clk_in);
    keys_out <= 5'h00;
    store_out <= 1'b0;
    repeat (8) @(posedge clk_in); // let the display settle
  endtask
endmodule

// [verification/tse_editor_test.sv]
// self-checking bench for the trimming sequence editor
`timescale 1ns/1ps
module tse_editor_test;
  import tse_pkg::*;
  typedef struct packed {
    logic [2:0] key;
    logic [7:0] reps;
    logic [2:0] mode;
    logic [6:0] item;
    logic [7:0] value;
  } tse_row_t;
  // key, presses, then expected mode, item, value
  localparam tse_row_t ROWS [19] = '{
    '{3'h5, 8'h01, 3'h1, 7'h00, 8'h00}, '{3'h1, 8'h01, 3'h2, 7'h01, 8'h00},
    '{3'h1, 8'h01, 3'h2, 7'h01, 8'h00}, '{3'h2, 8'h01, 3'h2, 7'h01, 8'h00},
    '{3'h0, 8'h36, 3'h2, 7'h37, 8'h00}, '{3'h2, 8'h01, 3'h3, 7'h37, 8'h00},
    '{3'h2, 8'h01, 3'h4, 7'h00, 8'h80}, '{3'h0, 8'h01, 3'h4, 7'h00, 8'h81},
    '{3'h1, 8'h01, 3'h4, 7'h00, 8'h80}, '{3'h3, 8'h01, 3'h4, 7'h00, 8'h80},
    '{3'h2, 8'h01, 3'h4, 7'h00, 8'h08}, '{3'h2, 8'h01, 3'h4, 7'h00, 8'hF3},
    '{3'h1, 8'h40, 3'h4, 7'h00, 8'hB3}, '{3'h2, 8'h01, 3'h4, 7'h00, 8'h00},
    '{3'h0, 8'h05, 3'h4, 7'h00, 8'h05},
    '{3'h6, 8'h01, 3'h4, 7'h00, 8'h05}, '{3'h3, 8'h01, 3'h4, 7'h00, 8'hB3},
    '{3'h2, 8'h01, 3'h4, 7'h00, 8'h05}, '{3'h4, 8'h01, 3'h1, 7'h00, 8'h00}};
  logic clk, resetn, store, run, save, valid, done;
  logic [7:0] data1;
  logic [7:0] last_data = 8'h00;
  logic [4:0] keys;
  logic [3:0] sel;
  logic [2:0] mode;
  logic [6:0] item;
  logic [7:0] value, code;
  int n_errors = 0, checks_done = 0, n_saves = 0, n_cmds = 0;
  logic [7:0] last_code = 8'h00;
  tse_panel i_tse_panel (.clk_in(clk), .keys_out(keys), .store_out(store));
  tse_editor i_tse_editor (.CLK_IN(clk), .RESETN_IN(resetn),
    .KEY_A_IN(keys[0]), .KEY_B_IN(keys[1]), .KEY_C_IN(keys[2]),
    .KEY_D_IN(keys[3]), .KEY_E_IN(keys[4]), .KEY_STORE_IN(store),
    .SEQ_SELECT_IN(sel), .RUN_IN(run), .DISP_MODE_OUT(mode),
    .DISP_VALUE_OUT(value), .DISP_ITEM_OUT(item), .SAVE_OUT(save),
    .CMD_VALID_OUT(valid), .CMD_CODE_OUT(code), .CMD_DATA1_OUT(data1),
    .CMD_DATA2_OUT(), .CMD_DATA3_OUT(), .RUN_DONE_OUT(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count save pulses and issued commands
  always @(posedge clk) begin
    if (save === 1'b1) n_saves++;
    if (valid === 1'b1) begin
      n_cmds++;
      last_code = code;
      last_data = data1;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // start the interpreter on one sequence and wait for its end
  task automatic run_seq(input logic [3:0] s);
    int n;
    @(posedge clk);
    sel <= s;
    repeat (4) @(posedge clk);
    run <= 1'b1;
    repeat (4) @(posedge clk);
    run <= 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) @(posedge clk);
    if (n == 300) begin
      n_errors++;
      end_of_test();
    end
  endtask
  initial begin
    resetn = 1'b0;
    sel = 4'h0;
    run = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    foreach (ROWS[i]) begin
      repeat (ROWS[i].reps) i_tse_panel.press(ROWS[i].key);
      chk(8'(mode), 8'(ROWS[i].mode));
      chk(value, ROWS[i].value);
      if (mode === 3'h2 || mode === 3'h3)
        chk(8'(item), 8'(ROWS[i].item));
    end
    chk(8'(n_saves), 8'h02);
    run_seq(4'h0);
    chk(8'(n_cmds), 8'h01);
    chk(last_code, CODE_DLY_HI);
    chk(last_data, 8'h05);
    run_seq(4'h1);
    chk(8'(n_cmds), 8'h01);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    chk(8'(mode), 8'h00);
    resetn <= 1'b1;
    i_tse_panel.press(3'h5);
    chk(8'(mode), 8'h01);
    end_of_test();
  end
endmodule
